//--- logic/ris_pkg.sv
// register map, field layout, reset values and modes of the reference input selector
package ris_pkg;
	localparam logic [7:0] ADDR_PRIO = 8'h14;
	localparam logic [7:0] ADDR_MODE = 8'h15;
	localparam logic [7:0] ADDR_HOLD = 8'h16;
	localparam logic [7:0] ADDR_CDIV = 8'h17;
	localparam logic [7:0] RST_PRIO = 8'hE0;
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [7:0] RST_HOLD = 8'h80;
	localparam logic [7:0] RST_CDIV = 8'h82;
	localparam int MASK_LOR_BIT = 6;
	localparam int PREDIV_BIT = 5;
	localparam int REVERTIVE_SWITCH_ENABLE_BIT = 4;
	localparam int MODE_LSB = 2;
	localparam int TDIV_LSB = 6;
	localparam int PD_LSB = 2;
	localparam logic [7:0] MODE_WMASK = 8'h7F;
	localparam logic [7:0] CDIV_WMASK = 8'hCF;
	localparam int NUM_INPUTS = 4;
	typedef enum logic [1:0] {
		RIS_MANUAL = 2'h0,
		RIS_AUTO = 2'h1,
		RIS_HOLD_SHORT = 2'h2,
		RIS_AUTO_HOLD = 2'h3
	} ris_mode_t;
	// tick divider exponents for holdoff codes 00..11; code 10 is 2**17
	localparam int TDIV_EXP0 = 15;
	localparam int TDIV_EXP1 = 16;
	localparam int TDIV_EXP2 = 17;
	localparam int TDIV_EXP3 = 18;
	// revalidation periods per code, /1 and /4 pre-divider
	localparam logic [8:0] REVAL_D1_0 = 9'h002;
	localparam logic [8:0] REVAL_D1_1 = 9'h010;
	localparam logic [8:0] REVAL_D1_2 = 9'h020;
	localparam logic [8:0] REVAL_D1_3 = 9'h040;
	localparam logic [8:0] REVAL_D4_0 = 9'h008;
	localparam logic [8:0] REVAL_D4_1 = 9'h040;
	localparam logic [8:0] REVAL_D4_2 = 9'h080;
	localparam logic [8:0] REVAL_D4_3 = 9'h100;
endpackage : ris_pkg

//--- logic/ris_reval.sv
// per-input revalidation counter holding the loss-of-signal flag
`timescale 1ns/1ns
module ris_reval (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic los_event,
	input wire logic period_ok,
	input wire logic edge_missing,
	input wire logic [8:0] setting,
	output logic los_flag,
	output logic revalidated
);
	logic [8:0] count;
	logic [8:0] next_count;
	logic next_los_flag;
	logic next_revalidated;

	always_comb begin
		next_count = count;
		next_los_flag = los_flag;
		next_revalidated = 1'b0;
		if (los_event) begin
			next_count = setting;
			next_los_flag = 1'b1;
		end else if (los_flag && edge_missing) begin
			next_count = setting;
		end else if (los_flag && period_ok) begin
			if (count <= 9'h001) begin
				next_los_flag = 1'b0;
				next_revalidated = 1'b1;
				next_count = 9'h000;
			end else begin
				next_count = count - 9'h001;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= 9'h000;
			los_flag <= 1'b0;
			revalidated <= 1'b0;
		end else begin
			count <= next_count;
			los_flag <= next_los_flag;
			revalidated <= next_revalidated;
		end
	end
endmodule : ris_reval

//--- logic/ris_top.sv
// reference input selector: registers, priority selection, holdoff and revalidation
`timescale 1ns/1ns
module ris_top #(
	parameter int TDIV_MAX_EXP = ris_pkg::TDIV_EXP3
) (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	output logic [7:0] REG_RDATA,
	input wire logic [3:0] LOS_EVENT,
	input wire logic [3:0] PERIOD_OK,
	input wire logic [3:0] EDGE_MISSING,
	input wire logic PLL_UNLOCK,
	output logic [1:0] REF_SELECT,
	output logic [3:0] LOS_FLAG,
	output logic [3:0] INPUT_POWER_DOWN,
	output logic LOSS_OF_LOCK,
	output logic LOCK
);
	localparam int NI = ris_pkg::NUM_INPUTS;
	logic [7:0] prio_reg;
	logic [7:0] mode_reg;
	logic [7:0] hold_reg;
	logic [7:0] cdiv_reg;
	logic [7:0] next_prio_reg;
	logic [7:0] next_mode_reg;
	logic [7:0] next_hold_reg;
	logic [7:0] next_cdiv_reg;
	logic [1:0] sel_mode;
	logic [1:0] man_sel;
	logic revertive_switch_enable_on;
	logic [8:0] reval_set;
	logic [NI-1:0] reval_done;
	logic [1:0] cur_ref;
	logic [1:0] next_cur_ref;
	logic [7:0] hold_cnt;
	logic [7:0] next_hold_cnt;
	logic hold_run;
	logic next_hold_run;
	logic [TDIV_MAX_EXP-1:0] tick_cnt;
	logic [TDIV_MAX_EXP-1:0] next_tick_cnt;
	logic [TDIV_MAX_EXP-1:0] tick_top;
	logic tick;
	logic best_valid;
	logic [1:0] best_idx;
	logic [1:0] best_pri;
	logic lor;
	logic next_lol;

	// register file
	always_comb begin
		next_prio_reg = prio_reg;
		next_mode_reg = mode_reg;
		next_hold_reg = hold_reg;
		next_cdiv_reg = cdiv_reg;
		if (REG_WR) begin
			unique case (REG_ADDR)
				ris_pkg::ADDR_PRIO: next_prio_reg = REG_WDATA;
				ris_pkg::ADDR_MODE: next_mode_reg = REG_WDATA & ris_pkg::MODE_WMASK;
				ris_pkg::ADDR_HOLD: next_hold_reg = REG_WDATA;
				ris_pkg::ADDR_CDIV: next_cdiv_reg = REG_WDATA & ris_pkg::CDIV_WMASK;
				default: ;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			prio_reg <= ris_pkg::RST_PRIO;
			mode_reg <= ris_pkg::RST_MODE;
			hold_reg <= ris_pkg::RST_HOLD;
			cdiv_reg <= ris_pkg::RST_CDIV;
		end else begin
			prio_reg <= next_prio_reg;
			mode_reg <= next_mode_reg;
			hold_reg <= next_hold_reg;
			cdiv_reg <= next_cdiv_reg;
		end
	end

	always_comb begin
		unique case (REG_ADDR)
			ris_pkg::ADDR_PRIO: REG_RDATA = prio_reg;
			ris_pkg::ADDR_MODE: REG_RDATA = mode_reg;
			ris_pkg::ADDR_HOLD: REG_RDATA = hold_reg;
			ris_pkg::ADDR_CDIV: REG_RDATA = cdiv_reg;
			default: REG_RDATA = 8'h00;
		endcase
	end

	assign sel_mode = mode_reg[ris_pkg::MODE_LSB +: 2];
	assign man_sel = mode_reg[1:0];
	assign revertive_switch_enable_on = mode_reg[ris_pkg::REVERTIVE_SWITCH_ENABLE_BIT] & sel_mode[0];
	assign INPUT_POWER_DOWN = {2'h0, cdiv_reg[ris_pkg::PD_LSB +: 2]};

	// revalidation count from code and pre-divider
	always_comb begin
		unique case ({mode_reg[ris_pkg::PREDIV_BIT], cdiv_reg[1:0]})
			3'h0: reval_set = ris_pkg::REVAL_D1_0;
			3'h1: reval_set = ris_pkg::REVAL_D1_1;
			3'h2: reval_set = ris_pkg::REVAL_D1_2;
			3'h3: reval_set = ris_pkg::REVAL_D1_3;
			3'h4: reval_set = ris_pkg::REVAL_D4_0;
			3'h5: reval_set = ris_pkg::REVAL_D4_1;
			3'h6: reval_set = ris_pkg::REVAL_D4_2;
			default: reval_set = ris_pkg::REVAL_D4_3;
		endcase
	end

	for (genvar i = 0; i < NI; i++) begin : g_reval
		ris_reval u_reval (
			.clk(CLK_SYS),
			.rst_n(RST_N),
			.los_event(LOS_EVENT[i]),
			.period_ok(PERIOD_OK[i]),
			.edge_missing(EDGE_MISSING[i]),
			.setting(reval_set),
			.los_flag(LOS_FLAG[i]),
			.revalidated(reval_done[i])
		);
	end

	// best available input; strict greater keeps lower index on ties
	always_comb begin
		best_valid = 1'b0;
		best_idx = 2'h0;
		best_pri = 2'h0;
		for (int i = 0; i < NI; i++) begin
			if (!LOS_FLAG[i] && (!best_valid ||
				prio_reg[7-2*i -: 2] > best_pri)) begin
				best_valid = 1'b1;
				best_idx = 2'(i);
				best_pri = prio_reg[7-2*i -: 2];
			end
		end
	end

	// tick divider only meaningful in auto-with-holdover
	always_comb begin
		unique case (cdiv_reg[ris_pkg::TDIV_LSB +: 2])
			2'h0: tick_top = TDIV_MAX_EXP'((64'h1 << ris_pkg::TDIV_EXP0) - 64'h1);
			2'h1: tick_top = TDIV_MAX_EXP'((64'h1 << ris_pkg::TDIV_EXP1) - 64'h1);
			2'h2: tick_top = TDIV_MAX_EXP'((64'h1 << ris_pkg::TDIV_EXP2) - 64'h1);
			default: tick_top = TDIV_MAX_EXP'((64'h1 << ris_pkg::TDIV_EXP3) - 64'h1);
		endcase
	end

	assign tick = hold_run && (tick_cnt >= tick_top);

	always_comb begin
		next_cur_ref = cur_ref;
		next_hold_run = hold_run;
		next_hold_cnt = hold_cnt;
		next_tick_cnt = tick_run_inc(tick_cnt, hold_run, tick);
		unique case (ris_pkg::ris_mode_t'(sel_mode))
			ris_pkg::RIS_MANUAL, ris_pkg::RIS_HOLD_SHORT: begin
				next_cur_ref = man_sel;
				next_hold_run = 1'b0;
				next_hold_cnt = hold_reg;
			end
			ris_pkg::RIS_AUTO: begin
				next_hold_run = 1'b0;
				next_hold_cnt = hold_reg;
				if (LOS_FLAG[cur_ref] && best_valid) begin
					next_cur_ref = best_idx;
				end else if (revertive_switch_enable_on && |(reval_done & ~(4'h1 << cur_ref)) && best_valid &&
					best_pri > prio_reg[7-2*cur_ref -: 2]) begin
					next_cur_ref = best_idx;
				end
			end
			ris_pkg::RIS_AUTO_HOLD: begin
				if (LOS_FLAG[cur_ref] && !hold_run) begin
					next_hold_run = 1'b1;
					next_hold_cnt = hold_reg;
				end else if (hold_run && tick) begin
					if (hold_cnt <= 8'h01) begin
						next_hold_cnt = hold_reg;
						next_hold_run = 1'b0;
						if (LOS_FLAG[cur_ref] && best_valid) begin
							next_cur_ref = best_idx;
						end
					end else begin
						next_hold_cnt = hold_cnt - 8'h01;
					end
				end else if (!LOS_FLAG[cur_ref] && hold_run) begin
					next_hold_run = 1'b0;
					next_hold_cnt = hold_reg;
				end
				if (!hold_run && revertive_switch_enable_on && |(reval_done & ~(4'h1 << cur_ref)) &&
					best_valid && best_pri > prio_reg[7-2*cur_ref -: 2]) begin
					next_cur_ref = best_idx;
				end
			end
		endcase
	end

	function automatic logic [TDIV_MAX_EXP-1:0] tick_run_inc(
		input logic [TDIV_MAX_EXP-1:0] c,
		input logic run,
		input logic t
	);
		if (!run || t) return '0;
		return c + TDIV_MAX_EXP'(1);
	endfunction : tick_run_inc

	assign lor = LOS_FLAG[cur_ref];
	assign next_lol = PLL_UNLOCK | (lor & ~mode_reg[ris_pkg::MASK_LOR_BIT]);

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			cur_ref <= 2'h0;
			hold_run <= 1'b0;
			hold_cnt <= ris_pkg::RST_HOLD;
			tick_cnt <= '0;
			LOSS_OF_LOCK <= 1'b0;
		end else begin
			cur_ref <= next_cur_ref;
			hold_run <= next_hold_run;
			hold_cnt <= next_hold_cnt;
			tick_cnt <= next_tick_cnt;
			LOSS_OF_LOCK <= next_lol;
		end
	end

	assign REF_SELECT = cur_ref;
	assign LOCK = ~LOSS_OF_LOCK;
endmodule : ris_top

//--- testbench/ris_checker_assertions.sv
// port-level checker for the reference input selector
`timescale 1ns/1ns
module ris_checker #(
	parameter int TDIV_MAX_EXP = 18
) (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic [7:0] REG_RDATA,
	input wire logic [3:0] LOS_EVENT,
	input wire logic [3:0] PERIOD_OK,
	input wire logic PLL_UNLOCK,
	input wire logic [1:0] REF_SELECT,
	input wire logic [3:0] LOS_FLAG,
	input wire logic LOSS_OF_LOCK,
	input wire logic LOCK
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	sequence manual_wr;
		REG_WR && REG_ADDR == 8'h15 && !REG_WDATA[2];
	endsequence
	sequence sel_lands;
		##2 REF_SELECT == $past(REG_WDATA[1:0], 2);
	endsequence
	lock_inverse_a: assert property (LOCK == !LOSS_OF_LOCK)
		else $error("lock not inverse");
	unlock_lol_a: assert property (PLL_UNLOCK |=> LOSS_OF_LOCK)
		else $error("unlock ignored");
	lol_clear_a: assert property (!PLL_UNLOCK && LOS_FLAG == 4'h0 |=> !LOSS_OF_LOCK)
		else $error("spurious loss of lock");
	flag_set_a: assert property (
		|LOS_EVENT |=> (LOS_FLAG & $past(LOS_EVENT)) == $past(LOS_EVENT))
		else $error("loss flag not set");
	flag_clear_a: assert property (
		($past(LOS_FLAG) & ~LOS_FLAG & ~$past(PERIOD_OK)) == 4'h0)
		else $error("flag cleared without period");
	flag_rise_a: assert property (
		(~$past(LOS_FLAG) & LOS_FLAG & ~$past(LOS_EVENT)) == 4'h0)
		else $error("flag set without event");
	manual_sel_a: assert property (manual_wr |-> sel_lands)
		else $error("manual select lost");
	unmapped_read_a: assert property (
		(REG_ADDR < 8'h14 || REG_ADDR > 8'h17) |-> REG_RDATA == 8'h00)
		else $error("unmapped read not zero");
endmodule : ris_checker
bind ris_top ris_checker #(.TDIV_MAX_EXP(TDIV_MAX_EXP)) ris_checker_inst (.CLK_SYS(CLK_SYS),
	.RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
	.REG_RDATA(REG_RDATA), .LOS_EVENT(LOS_EVENT), .PERIOD_OK(PERIOD_OK), .PLL_UNLOCK(PLL_UNLOCK),
	.REF_SELECT(REF_SELECT), .LOS_FLAG(LOS_FLAG), .LOSS_OF_LOCK(LOSS_OF_LOCK), .LOCK(LOCK));

//--- testbench/ris_monitor_model.sv
// activity monitor stand-in: one pulse per input period, loss and missing-edge events
`timescale 1ns/1ns
module ris_monitor_model (
	input wire logic clk,
	input wire logic [3:0] alive,
	input wire logic [3:0] miss,
	output logic [3:0] los_event = 4'h0,
	output logic [3:0] period_ok = 4'h0,
	output logic [3:0] edge_missing = 4'h0
);
	logic [3:0] was = 4'hF;
	// inputs sampled on the edge, outputs launched just after it, so no race with the bench
	always @(posedge clk) begin
		los_event <= #1 was & ~alive;
		period_ok <= #1 alive & ~miss;
		edge_missing <= #1 alive & miss;
		was <= alive;
	end
endmodule : ris_monitor_model

//--- testbench/reference_input_selector_tb.sv
// self-checking bench for the reference input selector
`timescale 1ns/1ns
module reference_input_selector_tb;
	logic clk = 0, rst_n = 0, wr = 0, unlock = 0, lol, lock;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	logic [3:0] alive = 4'hF, miss = 4'h0, los_ev, per_ok, edge_m, flag, pd;
	logic [1:0] ref_sel;
	int fails = 0, n_tests = 0, cyc = 0, seed = 32'hdd9128f4, prio, cur;
	always #2 clk = ~clk;
	ris_monitor_model ris_monitor_model_inst (.clk(clk), .alive(alive), .miss(miss),
		.los_event(los_ev), .period_ok(per_ok), .edge_missing(edge_m));
	ris_top ris_top_inst (.CLK_SYS(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_WR(wr), .REG_RDATA(rdata), .LOS_EVENT(los_ev), .PERIOD_OK(per_ok),
		.EDGE_MISSING(edge_m), .PLL_UNLOCK(unlock), .REF_SELECT(ref_sel), .LOS_FLAG(flag),
		.INPUT_POWER_DOWN(pd), .LOSS_OF_LOCK(lol), .LOCK(lock));
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : print_verdict
	always @(posedge clk) begin
		cyc <= cyc + 1;
		// holdoff scenario alone needs two ticks of 2**15 cycles
		if (cyc == 80000) begin
			fails++;
			print_verdict();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic cycles(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cycles
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		cycles(1);
		addr = a;
		wdata = d;
		wr = 1;
		cycles(1);
		wr = 0;
	endtask : wr_reg
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		cycles(1);
		addr = a;
		#1;
		check(rdata, e);
	endtask : rd_chk
	function automatic int pr(input int p, input int i);
		return (p >> (6 - 2 * i)) & 3;
	endfunction : pr
	// highest priority unflagged input, lower index wins a tie
	function automatic int best(input int p, input logic [3:0] f);
		int b = 0;
		int bp = -1;
		for (int i = 0; i < 4; i++) begin
			if (!f[i] && pr(p, i) > bp) begin
				b = i;
				bp = pr(p, i);
			end
		end
		return b;
	endfunction : best
	// counts valid periods seen while flagged, one missing edge after kmiss of them
	task automatic reval(input int i, input int nexp, input int kmiss);
		int c = 0;
		alive[i] = 1;
		repeat (600) begin
			@(negedge clk);
			if (!flag[i]) break;
			c += int'(per_ok[i]);
			miss[i] = per_ok[i] && c == kmiss;
		end
		check(8'(c), 8'(nexp + kmiss));
	endtask : reval
	initial begin
		cycles(6);
		rst_n = 1;
		rd_chk(8'h14, 8'hE0);
		rd_chk(8'h15, 8'h00);
		rd_chk(8'h16, 8'h80);
		rd_chk(8'h17, 8'h82);
		rd_chk(8'h30, 8'h00);
		wr_reg(8'h15, 8'h81);
		cycles(2);
		check(8'(ref_sel), 8'h01);
		rd_chk(8'h15, 8'h01);
		wr_reg(8'h17, 8'hFF);
		cycles(2);
		rd_chk(8'h17, 8'hCF);
		check(8'(pd), 8'h03);
		wr_reg(8'h17, 8'h82);
		alive[1] = 0;
		cycles(4);
		check({7'h00, lock}, 8'h00);
		wr_reg(8'h15, 8'h41);
		cycles(2);
		check({7'h00, lock}, 8'h01);
		reval(1, 32, 1 + ($random(seed) & 15));
		wr_reg(8'h15, 8'h61);
		alive[1] = 0;
		cycles(4);
		reval(1, 128, 1 + ($random(seed) & 15));
		unlock = 1;
		cycles(2);
		check({7'h00, lock}, 8'h00);
		unlock = 0;
		wr_reg(8'h15, 8'h18);
		alive[0] = 0;
		cycles(4);
		check(8'(ref_sel), 8'h00);
		reval(0, 32, 3);
		cycles(2);
		check(8'(ref_sel), 8'h00);
		for (int t = 0; t < 6; t++) begin
			prio = $random(seed) & 255;
			wr_reg(8'h14, 8'(prio));
			wr_reg(8'h15, 8'h00);
			wr_reg(8'h15, {3'h0, t[0], 4'h4});
			alive[0] = 0;
			cycles(4);
			cur = best(prio, 4'h1);
			check(8'(ref_sel), 8'(cur));
			reval(0, 32, 1 + ($random(seed) & 7));
			cycles(2);
			check(8'(ref_sel), (t[0] && pr(prio, 0) > pr(prio, cur)) ? 8'h00 : 8'(cur));
		end
		// shortest tick divider and two holdoff ticks keep the run short
		wr_reg(8'h16, 8'h02);
		wr_reg(8'h17, 8'h02);
		rd_chk(8'h16, 8'h02);
		wr_reg(8'h15, 8'h00);
		wr_reg(8'h15, 8'h0C);
		alive[0] = 0;
		cycles(20);
		check(8'(ref_sel), 8'h00);
		cycles((2 << ris_pkg::TDIV_EXP0) - 28);
		check(8'(ref_sel), 8'h00);
		cycles(16);
		check(8'(ref_sel), 8'(best(prio, 4'h1)));
		print_verdict();
	end
endmodule : reference_input_selector_tb
